// ===== wavefront_simd_dispatch.sv
// Wavefront spawn, lock-step issue and mask control for one compute unit.
// Assumes lane array and fetch units on the same clock, answering in time.
`include "wf_map.svh"
`default_nettype none
module wavefront_simd_dispatch
    import wf_pkg::*;
#(
    parameter int WAVE = `WF_SIZE_FULL,
    parameter int NUM_WF = 4,
    parameter int PC_W = 16,
    parameter int SIZE_W = 9,
    parameter bit NEW_FAMILY = 1'b1
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic wg_valid_i,
    input wire logic [SIZE_W-1:0] wg_size_i,
    input wire logic [PC_W-1:0] wg_pc_i,
    output logic wg_ready_o,
    output logic wg_done_o,
    output logic issue_valid_o,
    output logic issue_last_o,
    output logic [$clog2(NUM_WF)-1:0] issue_wf_o,
    output logic [PC_W-1:0] issue_pc_o,
    output logic [1:0] issue_quad_o,
    output logic [`WF_LANES-1:0] issue_lane_en_o,
    output logic [SIZE_W-1:0] issue_item_base_o,
    input wire instr_kind_t fb_kind_i,
    input wire logic [WAVE-1:0] fb_cond_i,
    input wire logic [PC_W-1:0] fb_target_i,
    input wire mem_op_t mem_op_i,
    input wire logic mem_image_i,
    input wire logic mem_2d_i,
    input wire logic mem_norm_i,
    input wire logic mem_read_only_i,
    input wire logic mem_consec_i,
    input wire logic [7:0] mem_bind_i,
    input wire logic [15:0] mem_x_i,
    input wire logic [15:0] mem_y_i,
    output logic mem_req_o,
    output mem_op_t mem_req_op_o,
    output logic [$clog2(NUM_WF)-1:0] mem_req_wf_o,
    output logic [WAVE-1:0] mem_req_lanes_o,
    output logic mem_burst_o,
    output logic mem_cached_o,
    output logic mem_fault_o,
    input wire logic mem_done_i,
    input wire logic [$clog2(NUM_WF)-1:0] mem_done_wf_i
);
    localparam int QUADS = WAVE / `WF_LANES;
    localparam int QM1 = QUADS - 1;
    localparam int WF_W = $clog2(NUM_WF);

    // Per-wavefront state; one mask level deep, no nested branches
    logic [NUM_WF-1:0] valid_ff, park_ff;
    logic [PC_W-1:0] pc_ff [NUM_WF];
    logic [PC_W-1:0] else_pc_ff [NUM_WF];
    logic [WAVE-1:0] mask_ff [NUM_WF];
    logic [WAVE-1:0] save_ff [NUM_WF];
    logic [WAVE-1:0] else_ff [NUM_WF];
    logic [WAVE-1:0] exit_ff [NUM_WF];
    logic [WF_W-1:0] cur_ff, rr_ff, pick, cand;
    logic pick_ok, ready_ff, grp_busy_ff, done_ff;
    logic [SIZE_W-1:0] grp_size_ff;
    logic iss_valid_ff, iss_last_ff;
    logic [1:0] iss_quad_ff;
    logic [WF_W-1:0] iss_wf_ff, mem_wf_ff;
    logic [PC_W-1:0] iss_pc_ff;
    logic [`WF_LANES-1:0] iss_lane_ff;
    logic [SIZE_W-1:0] iss_base_ff;
    logic mem_req_ff, mem_fault_ff, mem_burst_ff, mem_cached_ff;
    mem_op_t mem_op_ff;
    logic [WAVE-1:0] mem_lanes_ff;
    logic [PC_W-1:0] nxt_pc, nxt_else_pc;
    logic [WAVE-1:0] nxt_mask, nxt_save, nxt_else, nxt_exit;
    logic [WAVE-1:0] init_mask [NUM_WF];
    logic [NUM_WF-1:0] init_valid;
    logic seq_busy, seq_last;
    logic [1:0] seq_quad;
    logic chk_fault, chk_cached, chk_burst;

    // Linear item to lane mapping; partial wavefronts leave lanes off
    for (genvar k = 0; k < NUM_WF; k++) begin : g_spawn
        for (genvar l = 0; l < WAVE; l++) begin : g_lane
            assign init_mask[k][l] =
                32'(k * WAVE + l) < 32'(wg_size_i);
        end
        assign init_valid[k] = init_mask[k][0];
    end

    wire accept = wg_valid_i & ready_ff;
    wire [NUM_WF-1:0] elig = valid_ff & ~park_ff;
    wire fb_take = iss_valid_ff & iss_last_ff;
    wire [WAVE-1:0] cur_mask = mask_ff[cur_ff];
    wire [WAVE-1:0] cur_save = save_ff[cur_ff];
    wire [WAVE-1:0] cur_else = else_ff[cur_ff];
    wire [WAVE-1:0] cur_exit = exit_ff[cur_ff];
    wire [PC_W-1:0] cur_pc = pc_ff[cur_ff];
    wire [WAVE-1:0] taken = cur_mask & fb_cond_i;
    wire [WAVE-1:0] not_t = cur_mask & ~fb_cond_i;
    // One wavefront on the lanes at a time
    wire start = pick_ok & ~seq_busy & ~iss_valid_ff;
    wire is_mem = fb_take & (fb_kind_i == k_mem);
    wire [NUM_WF-1:0] cur_hot = NUM_WF'(1) << cur_ff;
    wire [NUM_WF-1:0] set_hot = (is_mem & ~chk_fault) ? cur_hot : '0;
    wire [NUM_WF-1:0] done_hot =
        mem_done_i ? (NUM_WF'(1) << mem_done_wf_i) : '0;
    wire [NUM_WF-1:0] end_hot =
        (fb_take & (fb_kind_i == k_end)) ? cur_hot : '0;
    wire grp_end = grp_busy_ff & (valid_ff == '0);
    wire [`WF_LANES-1:0] seq_lanes =
        cur_mask[int'(seq_quad) * `WF_LANES +: `WF_LANES];
    // Lane l serves items l, l+16, l+32, l+48 of the wavefront
    wire [SIZE_W-1:0] seq_base = SIZE_W'(int'(cur_ff) * WAVE
        + int'(seq_quad) * `WF_LANES);

    // Round robin over resident, unparked wavefronts
    always_comb begin
        pick = rr_ff;
        pick_ok = 1'b0;
        cand = rr_ff;
        for (int i = NUM_WF; i >= 1; i--) begin
            cand = WF_W'((int'(rr_ff) + i) % NUM_WF);
            if (elig[cand]) begin
                pick = cand;
                pick_ok = 1'b1;
            end
        end
    end

    // Control flow of the current wavefront, applied on its last quarter
    always_comb begin
        nxt_pc = cur_pc + PC_W'(1);
        nxt_mask = cur_mask;
        nxt_save = cur_save;
        nxt_else = cur_else;
        nxt_else_pc = else_pc_ff[cur_ff];
        nxt_exit = cur_exit;
        unique case (fb_kind_i)
            k_branch: begin
                nxt_save = cur_mask;
                nxt_else_pc = fb_target_i;
                if (taken != '0) begin
                    nxt_mask = taken;
                    nxt_else = not_t;
                end else begin
                    nxt_mask = not_t;
                    nxt_else = '0;
                    nxt_pc = fb_target_i;
                end
            end
            k_else: begin
                if (cur_else != '0) begin
                    nxt_mask = cur_else;
                    nxt_else = '0;
                    nxt_pc = else_pc_ff[cur_ff];
                end else begin
                    nxt_mask = cur_save;
                    nxt_pc = fb_target_i;
                end
            end
            k_join: nxt_mask = cur_save;
            k_loop: begin
                if (taken != '0) begin
                    nxt_exit = cur_exit | not_t;
                    nxt_mask = taken;
                    nxt_pc = fb_target_i;
                end else begin
                    nxt_mask = cur_exit | cur_mask;
                    nxt_exit = '0;
                end
            end
            k_alu, k_mem, k_end: ;
            default: ;
        endcase
    end

    quad_seq #(.QUADS(QUADS)) u_seq (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .start_i(start),
        .quad_o(seq_quad),
        .last_o(seq_last),
        .busy_o(seq_busy)
    );

    fetch_check #(.NEW_FAMILY(NEW_FAMILY)) u_chk (
        .op_i(mem_op_i),
        .image_i(mem_image_i),
        .two_d_i(mem_2d_i),
        .norm_i(mem_norm_i),
        .read_only_i(mem_read_only_i),
        .consec_i(mem_consec_i),
        .bind_i(mem_bind_i),
        .x_i(mem_x_i),
        .y_i(mem_y_i),
        .fault_o(chk_fault),
        .cached_o(chk_cached),
        .burst_o(chk_burst)
    );

    // Independent PC and mask per wavefront
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            for (int k = 0; k < NUM_WF; k++) begin
                pc_ff[k] <= '0;
                else_pc_ff[k] <= '0;
                mask_ff[k] <= '0;
                save_ff[k] <= '0;
                else_ff[k] <= '0;
                exit_ff[k] <= '0;
            end
        end else if (accept) begin
            for (int k = 0; k < NUM_WF; k++) begin
                pc_ff[k] <= wg_pc_i;
                else_pc_ff[k] <= '0;
                mask_ff[k] <= init_mask[k];
                save_ff[k] <= init_mask[k];
                else_ff[k] <= '0;
                exit_ff[k] <= '0;
            end
        end else if (fb_take) begin
            pc_ff[cur_ff] <= nxt_pc;
            else_pc_ff[cur_ff] <= nxt_else_pc;
            mask_ff[cur_ff] <= nxt_mask;
            save_ff[cur_ff] <= nxt_save;
            else_ff[cur_ff] <= nxt_else;
            exit_ff[cur_ff] <= nxt_exit;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            valid_ff <= '0;
            park_ff <= '0;
            grp_busy_ff <= 1'b0;
            ready_ff <= 1'b0;
            done_ff <= 1'b0;
            grp_size_ff <= '0;
            cur_ff <= '0;
            rr_ff <= '0;
        end else begin
            valid_ff <= accept ? init_valid : (valid_ff & ~end_hot);
            // Set wins over a completion in the same cycle
            park_ff <= (park_ff & ~done_hot) | set_hot;
            grp_busy_ff <= accept | (grp_busy_ff & ~grp_end);
            ready_ff <= ~accept & (ready_ff | grp_end | ~grp_busy_ff);
            done_ff <= grp_end;
            if (accept)
                grp_size_ff <= wg_size_i;
            if (start) begin
                cur_ff <= pick;
                rr_ff <= pick;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            iss_valid_ff <= 1'b0;
            iss_last_ff <= 1'b0;
            iss_quad_ff <= 2'h0;
            iss_wf_ff <= '0;
            iss_pc_ff <= '0;
            iss_lane_ff <= '0;
            iss_base_ff <= '0;
        end else begin
            iss_valid_ff <= seq_busy;
            iss_last_ff <= seq_last;
            iss_quad_ff <= seq_quad;
            iss_wf_ff <= cur_ff;
            iss_pc_ff <= cur_pc;
            iss_lane_ff <= seq_busy ? seq_lanes : '0;
            iss_base_ff <= seq_base;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            mem_req_ff <= 1'b0;
            mem_fault_ff <= 1'b0;
            mem_op_ff <= op_load;
            mem_wf_ff <= '0;
            mem_lanes_ff <= '0;
            mem_burst_ff <= 1'b0;
            mem_cached_ff <= 1'b0;
        end else begin
            mem_req_ff <= is_mem & ~chk_fault;
            mem_fault_ff <= is_mem & chk_fault;
            if (is_mem) begin
                mem_op_ff <= mem_op_i;
                mem_wf_ff <= cur_ff;
                mem_lanes_ff <= cur_mask;
                mem_burst_ff <= chk_burst;
                mem_cached_ff <= chk_cached;
            end
        end
    end

    assign wg_ready_o = ready_ff;
    assign wg_done_o = done_ff;
    assign issue_valid_o = iss_valid_ff;
    assign issue_last_o = iss_last_ff;
    assign issue_wf_o = iss_wf_ff;
    assign issue_pc_o = iss_pc_ff;
    assign issue_quad_o = iss_quad_ff;
    assign issue_lane_en_o = iss_lane_ff;
    assign issue_item_base_o = iss_base_ff;
    assign mem_req_o = mem_req_ff;
    assign mem_req_op_o = mem_op_ff;
    assign mem_req_wf_o = mem_wf_ff;
    assign mem_req_lanes_o = mem_lanes_ff;
    assign mem_burst_o = mem_burst_ff;
    assign mem_cached_o = mem_cached_ff;
    assign mem_fault_o = mem_fault_ff;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    a_lockstep_same: assert property (
        iss_valid_ff && !iss_last_ff |=> iss_valid_ff
        && $stable(iss_wf_ff) && $stable(iss_pc_ff))
        else $error("wavefront or pc changed inside an issue");
    a_quad_span: assert property (
        $rose(iss_valid_ff) |-> iss_quad_ff == 2'h0 ##QM1 iss_last_ff)
        else $error("issue did not span all quarters");
    a_linear_map: assert property (
        iss_valid_ff |-> iss_base_ff == SIZE_W'(int'(iss_wf_ff) * WAVE
        + int'(iss_quad_ff) * `WF_LANES))
        else $error("item base not linear");
    a_idle_lanes: assert property (
        iss_valid_ff && iss_base_ff >= grp_size_ff |-> iss_lane_ff == '0)
        else $error("lane enabled without a work-item");
    a_branch_then: assert property (
        fb_take && fb_kind_i == k_branch && taken != '0
        |=> cur_mask == $past(taken) && cur_else == $past(not_t))
        else $error("branch mask not split");
    a_empty_skip: assert property (
        fb_take && fb_kind_i == k_branch && taken == '0
        |=> cur_pc == $past(fb_target_i))
        else $error("empty path not skipped");
    a_mask_restore: assert property (
        fb_take && fb_kind_i == k_join |=> cur_mask == $past(cur_save))
        else $error("mask not restored at join");
    a_loop_stay: assert property (
        fb_take && fb_kind_i == k_loop && taken != '0
        |=> valid_ff[cur_ff] && cur_pc == $past(fb_target_i))
        else $error("looping wavefront left early");
    a_park_mem: assert property (
        mem_req_ff |-> park_ff[mem_wf_ff] && !iss_valid_ff)
        else $error("memory wavefront not parked");
    a_bind_fault: assert property (
        is_mem && mem_image_i && mem_op_i != op_load
        && mem_bind_i >= 8'(`WF_IMG_WR_MAX) |=> mem_fault_ff && !mem_req_ff)
        else $error("write image binding not refused");
    a_norm_edge: assert property (
        is_mem && mem_image_i && mem_norm_i && mem_op_i == op_load
        && (!mem_2d_i || mem_y_i == `WF_NORM_ONE) && mem_bind_i == 8'h00
        && mem_x_i == `WF_NORM_ONE |=> mem_req_ff)
        else $error("normalized 1.0 refused");

    c_divergent: cover property (
        fb_take && fb_kind_i == k_branch && taken != '0 && not_t != '0);
    c_loop_iter: cover property (fb_take && fb_kind_i == k_loop
        && taken != '0 && not_t != '0);
    c_mem_done: cover property (mem_req_ff ##[1:40] mem_done_i);
    c_group_done: cover property (done_ff);
endmodule
`default_nettype wire

// ===== wf_map.svh
// Constants of the wavefront dispatch block.
// Assumes inclusion by bare name before any use.
`ifndef WF_MAP_SVH
`define WF_MAP_SVH
`define WF_LANES 16
`define WF_SIZE_FULL 64
`define WF_SIZE_LOW 32
`define WF_IMG_RD_MAX 128
`define WF_IMG_WR_MAX 8
`define WF_IMG_LIM_OLD 8192
`define WF_IMG_LIM_NEW 16384
`define WF_NORM_ONE 16'h8000
`endif

// ===== wf_pkg.sv
// Types shared by the wavefront dispatch block.
// Assumes nothing of its surroundings.
`default_nettype none
package wf_pkg;
    typedef enum logic [2:0] {
        k_alu, k_branch, k_else, k_join, k_loop, k_mem, k_end
    } instr_kind_t;
    typedef enum logic [1:0] {op_load, op_store, op_stream} mem_op_t;
endpackage
`default_nettype wire

// ===== quad_seq.sv
// Quarter sequencer: steps one issued instruction over the lane quarters.
// Assumes start_i is only honoured while idle.
`include "wf_map.svh"
`default_nettype none
module quad_seq #(
    parameter int QUADS = 4
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic start_i,
    output logic [1:0] quad_o,
    output logic last_o,
    output logic busy_o
);
    localparam logic [1:0] QLAST = 2'(QUADS - 1);
    logic [1:0] quad_ff;
    logic busy_ff;
    wire at_last = busy_ff & (quad_ff == QLAST);

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            quad_ff <= 2'h0;
            busy_ff <= 1'b0;
        end else if (start_i & ~busy_ff) begin
            quad_ff <= 2'h0;
            busy_ff <= 1'b1;
        end else if (busy_ff) begin
            quad_ff <= at_last ? 2'h0 : quad_ff + 2'h1;
            busy_ff <= ~at_last;
        end
    end

    assign quad_o = quad_ff;
    assign last_o = at_last;
    assign busy_o = busy_ff;
endmodule
`default_nettype wire

// ===== fetch_check.sv
// Memory request classifier: image limits, caching and burst merging.
// Assumes normalized coordinates as unsigned Q1.15 fixed point.
`include "wf_map.svh"
`default_nettype none
module fetch_check
    import wf_pkg::*;
#(
    parameter bit NEW_FAMILY = 1'b1
) (
    input wire mem_op_t op_i,
    input wire logic image_i,
    input wire logic two_d_i,
    input wire logic norm_i,
    input wire logic read_only_i,
    input wire logic consec_i,
    input wire logic [7:0] bind_i,
    input wire logic [15:0] x_i,
    input wire logic [15:0] y_i,
    output logic fault_o,
    output logic cached_o,
    output logic burst_o
);
    localparam logic [15:0] LIMIT = NEW_FAMILY ?
        16'(`WF_IMG_LIM_NEW) : 16'(`WF_IMG_LIM_OLD);
    wire is_load = (op_i == op_load);
    // Separate binding tables for read and write images
    wire bind_bad = is_load ? (bind_i >= 8'(`WF_IMG_RD_MAX))
                            : (bind_i >= 8'(`WF_IMG_WR_MAX));
    // Both ends of the normalized range are legal
    wire x_bad = norm_i ? (x_i > `WF_NORM_ONE) : (x_i >= LIMIT);
    wire y_bad = two_d_i &
        (norm_i ? (y_i > `WF_NORM_ONE) : (y_i >= LIMIT));

    assign fault_o = image_i & (bind_bad | x_bad | y_bad);
    // Only read-only buffers and image reads are cached
    assign cached_o = is_load & (image_i | read_only_i);
    // Stores of any kind, linear buffer only
    assign burst_o = ~image_i & ~is_load & consec_i;
endmodule
`default_nettype wire

// ===== fetch_model.sv
// Fetch unit model: answers each accepted request with a done pulse.
// Assumes one access in flight and requests as one-cycle pulses.
`default_nettype none
module fetch_model (
    input wire logic clk_sys_i,
    input wire logic slow_i,
    input wire logic mem_req_i,
    input wire logic [1:0] mem_req_wf_i,
    output logic mem_done_o,
    output logic [1:0] mem_done_wf_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] w;
    initial begin
        mem_done_o = 1'b0;
        mem_done_wf_o = 2'h0;
        forever begin
            @(posedge clk_sys_i);
            if (mem_req_i === 1'b1) begin
                w = mem_req_wf_i;
                // Id shows only with the pulse, so a stale id cannot match
                #1 mem_done_wf_o = ~w;
                repeat (slow_i ? 30 : 2) @(posedge clk_sys_i);
                #1 mem_done_o = 1'b1;
                mem_done_wf_o = w;
                @(posedge clk_sys_i);
                #1 mem_done_o = 1'b0;
                mem_done_wf_o = ~w;
            end
        end
    end
endmodule
`default_nettype wire

// ===== wavefront_simd_dispatch_tb_top.sv
// Testbench of the wavefront dispatch block beside a fetch unit model.
// Assumes default sizes: 64-item wavefronts, four slots, newer family.
`default_nettype none
module wavefront_simd_dispatch_tb_top;
    import wf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i, reset_i, wg_valid_i, wg_ready_o, wg_done_o, slow;
    logic issue_valid_o, issue_last_o, mem_req_o, mem_burst_o;
    logic mem_cached_o, mem_fault_o, mem_done_i, mem_image_i, mem_2d_i;
    logic mem_norm_i, mem_read_only_i, mem_consec_i;
    logic [8:0] wg_size_i, issue_item_base_o;
    logic [15:0] wg_pc_i, issue_pc_o, fb_target_i, mem_x_i, mem_y_i;
    logic [1:0] issue_wf_o, issue_quad_o, mem_req_wf_o, mem_done_wf_i;
    logic [15:0] issue_lane_en_o;
    logic [63:0] fb_cond_i, mem_req_lanes_o;
    logic [7:0] mem_bind_i;
    instr_kind_t fb_kind_i;
    mem_op_t mem_op_i, mem_req_op_o;
    int errors, comparisons, cycles;
    localparam logic [63:0] C = 64'h0000_0000_ffff_00ff;

    wavefront_simd_dispatch wavefront_simd_dispatch_i (
        .clk_sys_i, .reset_i, .wg_valid_i, .wg_size_i, .wg_pc_i,
        .wg_ready_o, .wg_done_o, .issue_valid_o, .issue_last_o,
        .issue_wf_o, .issue_pc_o, .issue_quad_o, .issue_lane_en_o,
        .issue_item_base_o, .fb_kind_i, .fb_cond_i, .fb_target_i,
        .mem_op_i, .mem_image_i, .mem_2d_i, .mem_norm_i,
        .mem_read_only_i, .mem_consec_i, .mem_bind_i, .mem_x_i,
        .mem_y_i, .mem_req_o, .mem_req_op_o, .mem_req_wf_o,
        .mem_req_lanes_o, .mem_burst_o, .mem_cached_o, .mem_fault_o,
        .mem_done_i, .mem_done_wf_i
    );
    fetch_model fetch_model_i (
        .clk_sys_i, .slow_i(slow), .mem_req_i(mem_req_o),
        .mem_req_wf_i(mem_req_wf_o), .mem_done_o(mem_done_i),
        .mem_done_wf_o(mem_done_wf_i)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    task automatic end_sim();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic step();
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Follows one instruction over its quarters, answers on the last one
    task automatic instr(input instr_kind_t k, input logic [63:0] c,
            input logic [15:0] t, output logic [1:0] wf,
            output logic [15:0] pc, output logic [63:0] en);
        int n;
        n = 0;
        while (!(issue_valid_o === 1'b1 && issue_quad_o === 2'h0)
               && n < 200) begin
            step();
            n++;
        end
        chk(n < 200, 1'b1);
        wf = issue_wf_o;
        pc = issue_pc_o;
        for (int q = 0; q < 4; q++) begin
            if (q > 0) step();
            chk(issue_quad_o, q);
            chk(issue_pc_o, pc);
            chk(issue_item_base_o, wf * 64 + q * 16);
            chk(issue_last_o, q == 3);
            en[q*16+:16] = issue_lane_en_o;
        end
        fb_kind_i = k;
        fb_cond_i = c;
        fb_target_i = t;
        step();
    endtask

    task automatic ci(input logic [1:0] xwf, input logic [15:0] xpc,
            input logic [63:0] xen, input instr_kind_t k,
            input logic [63:0] c, input logic [15:0] t);
        logic [1:0] wf;
        logic [15:0] pc;
        logic [63:0] en;
        instr(k, c, t, wf, pc, en);
        chk(wf, xwf);
        chk(pc, xpc);
        chk(en, xen);
    endtask

    task automatic start(input logic [8:0] sz, input logic [15:0] pc);
        int n;
        n = 0;
        while (wg_ready_o !== 1'b1 && n < 50) begin
            step();
            n++;
        end
        wg_valid_i = 1'b1;
        wg_size_i = sz;
        wg_pc_i = pc;
        step();
        wg_valid_i = 1'b0;
        chk(wg_ready_o, 1'b0);
    endtask

    task automatic fin();
        int n;
        n = 0;
        while (wg_done_o !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        chk(wg_done_o, 1'b1);
    endtask

    task automatic t_spawn();
        start(9'h090, 16'h0040);
        // Round robin begins after slot 0, so slot 1 issues first
        ci(2'h1, 16'h0040, '1, k_alu, '0, '0);
        ci(2'h2, 16'h0040, 64'hffff, k_alu, '0, '0);
        ci(2'h0, 16'h0040, '1, k_branch, '0, 16'h0080);
        ci(2'h1, 16'h0041, '1, k_end, '0, '0);
        ci(2'h2, 16'h0041, 64'hffff, k_end, '0, '0);
        ci(2'h0, 16'h0080, '1, k_end, '0, '0);
        fin();
    endtask

    task automatic t_branch();
        start(9'h040, 16'h0010);
        ci(2'h0, 16'h0010, '1, k_branch, C, 16'h0020);
        ci(2'h0, 16'h0011, C, k_else, '0, 16'h0030);
        ci(2'h0, 16'h0020, ~C, k_join, '0, '0);
        ci(2'h0, 16'h0021, '1, k_loop, 64'h20, 16'h0021);
        ci(2'h0, 16'h0021, 64'h20, k_loop, 64'h20, 16'h0021);
        ci(2'h0, 16'h0021, 64'h20, k_loop, '0, 16'h0021);
        ci(2'h0, 16'h0022, '1, k_branch, '1, 16'h0030);
        ci(2'h0, 16'h0023, '1, k_else, '0, 16'h0040);
        ci(2'h0, 16'h0040, '1, k_end, '0, '0);
        fin();
    endtask

    // Flags are {image, 2d, normalized, read-only, consecutive}
    task automatic mc(input mem_op_t op, input logic [4:0] fl,
            input logic [7:0] b, input logic [15:0] x,
            input logic [15:0] y, input logic f);
        logic [1:0] w;
        logic [15:0] pc;
        logic [63:0] en;
        logic ld;
        mem_op_i = op;
        {mem_image_i, mem_2d_i, mem_norm_i, mem_read_only_i,
         mem_consec_i} = fl;
        mem_bind_i = b;
        mem_x_i = x;
        mem_y_i = y;
        instr(k_mem, '0, '0, w, pc, en);
        ld = (op == op_load);
        chk(mem_fault_o, f);
        chk(mem_req_o, !f);
        if (!f) begin
            chk(mem_req_op_o, op);
            chk(mem_burst_o, !fl[4] && !ld && fl[0]);
            chk(mem_cached_o, ld && (fl[4] || fl[1]));
        end
    endtask

    task automatic t_mem();
        start(9'h040, 16'h0100);
        mc(op_store, 5'h01, '0, '0, '0, 1'b0);
        mc(op_stream, 5'h01, '0, '0, '0, 1'b0);
        mc(op_load, 5'h02, '0, '0, '0, 1'b0);
        mc(op_load, 5'h00, '0, '0, '0, 1'b0);
        mc(op_load, 5'h18, 8'h7f, 16'h3fff, 16'h3fff, 1'b0);
        mc(op_load, 5'h10, 8'h80, '0, '0, 1'b1);
        mc(op_store, 5'h10, 8'h07, '0, '0, 1'b0);
        mc(op_stream, 5'h10, 8'h08, '0, '0, 1'b1);
        mc(op_load, 5'h18, '0, '0, 16'h4000, 1'b1);
        mc(op_load, 5'h10, '0, '0, 16'h4000, 1'b0);
        mc(op_load, 5'h1c, '0, 16'h8000, 16'h8000, 1'b0);
        mc(op_load, 5'h14, '0, 16'h8001, '0, 1'b1);
        ci(2'h0, 16'h010c, '1, k_end, '0, '0);
        fin();
    endtask

    task automatic t_park();
        logic [1:0] w0, w;
        logic [15:0] pc;
        logic [63:0] en;
        slow = 1'b1;
        start(9'h080, 16'h0000);
        mc(op_load, 5'h00, '0, '0, '0, 1'b0);
        w0 = mem_req_wf_o;
        chk(mem_req_lanes_o, '1);
        repeat (4) begin
            instr(k_alu, '0, '0, w, pc, en);
            chk(w, w0 ^ 2'h1);
        end
        instr(k_end, '0, '0, w, pc, en);
        instr(k_end, '0, '0, w, pc, en);
        chk(w, w0);
        fin();
        slow = 1'b0;
    endtask

    initial begin
        {reset_i, wg_valid_i, slow, mem_image_i, mem_2d_i} = 5'h10;
        {mem_norm_i, mem_read_only_i, mem_consec_i} = 3'h0;
        {wg_size_i, wg_pc_i, fb_target_i, mem_x_i, mem_y_i} = '0;
        {fb_cond_i, mem_bind_i} = '0;
        fb_kind_i = k_alu;
        mem_op_i = op_load;
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk(issue_valid_o, 1'b0);
        chk(mem_req_o, 1'b0);
        reset_i = 1'b0;
        t_spawn();
        t_branch();
        t_mem();
        t_park();
        end_sim();
    end

    // Cut a hang short well past the few hundred cycles needed
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end
endmodule
`default_nettype wire
